/* File: reload_timer_with_capture.sv */
// Purpose: 16-bit or dual 8-bit auto-reload timer with capture mode.
// Assumes: rtc_osc and cmp0_out are asynchronous and much slower than
//          ref_clk; the bus master holds its request while waiting.
// Notes: Every access takes one wait cycle.
// Notes on behaviour
// - Counter is a low and high byte; split select picks 16-bit or two 8-bit.
// - Sources: system clock, clock/12, rtc/8, comparator 0; last two synced.
// - 16-bit wrap from all ones loads reload value and sets high flag.
// - 16-bit mode: timer interrupt enable requests interrupt on each overflow.
// - 16-bit mode: with low interrupt enable, low byte wrap also interrupts.
// - Split mode: each byte reloads from its own reload byte on overflow.
// - Split mode: run gates only the high byte; low byte always counts.
// - Byte clock select one picks system clock, else alternate field decides.
// - Split mode: high wrap sets high flag, low wrap sets low flag.
// - Split mode: interrupt on high overflow, either byte if low enabled.
// - Flags are cleared only by software, which checks both for the source.
// - Writing capture enable one enters capture mode; use 16-bit mode then.
// - Capture event is comparator rising edge or every 8 rtc cycles.
// - Capture copies count into reload and sets high flag.
// - Low byte wrap sets low flag in every mode.
module reload_timer_with_capture
    import timer_pkg::*;
(
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic srst,
    // Avalon-MM register slave.
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Asynchronous count and capture sources.
    input wire logic rtc_osc,
    input wire logic cmp0_out,
    // Timer interrupt request.
    output logic timer_irq
);

    logic [2:0] rtc_sync_q, rtc_sync_d;
    logic [2:0] cmp_sync_q, cmp_sync_d;
    logic rtc_lvl_q, rtc_lvl_d;
    logic cmp_lvl_q, cmp_lvl_d;
    logic [3:0] div12_q, div12_d;
    logic [2:0] rtc8_q, rtc8_d;
    logic rtc_rise, cmp_rise, div12_tick, rtc8_tick;
    logic ack_q, ack_d;
    logic [31:0] rdata_q, rdata_d;
    logic wr_en;
    control_t ctrl_q, ctrl_d;
    clock_control_t clk_q, clk_d;
    logic [15:0] cnt_q, cnt_d;
    logic [15:0] rld_q, rld_d;
    logic low_tick, high_tick, lo_wrap, hi_wrap, cap_evt;

    // Picks one byte's count tick from its clock select and alt field.
    function automatic logic pick_tick(input logic sys_sel,
                                       input logic [1:0] alt,
                                       input logic d12,
                                       input logic r8,
                                       input logic c0);
        logic t;
        t = 1'b0;
        if (sys_sel)
            t = 1'b1;
        else if (alt == ALT_SYS_DIV12)
            t = d12;
        else if (alt == ALT_RTC_DIV8)
            t = r8;
        else if (alt == ALT_COMPARATOR)
            t = c0;
        return t;
    endfunction : pick_tick

    // Three-stage synchronisers, edge filters and prescalers.
    always_comb
    begin
        rtc_sync_d = {rtc_sync_q[1:0], rtc_osc};
        cmp_sync_d = {cmp_sync_q[1:0], cmp0_out};
        rtc_lvl_d = rtc_lvl_q;
        cmp_lvl_d = cmp_lvl_q;
        if (rtc_sync_q[1] == rtc_sync_q[2])
            rtc_lvl_d = rtc_sync_q[2];
        if (cmp_sync_q[1] == cmp_sync_q[2])
            cmp_lvl_d = cmp_sync_q[2];
        rtc_rise = rtc_lvl_d & ~rtc_lvl_q;
        cmp_rise = cmp_lvl_d & ~cmp_lvl_q;
        div12_tick = (div12_q == DIV12_LAST);
        div12_d = div12_tick ? 4'h0 : 4'(div12_q + 4'h1);
        rtc8_tick = rtc_rise && (rtc8_q == RTC_DIV_LAST);
        rtc8_d = rtc_rise ? 3'(rtc8_q + 3'h1) : rtc8_q;
    end

    // Registers for the source conditioning.
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            rtc_sync_q <= 3'h0;
            cmp_sync_q <= 3'h0;
            rtc_lvl_q <= 1'b0;
            cmp_lvl_q <= 1'b0;
            div12_q <= 4'h0;
            rtc8_q <= 3'h0;
        end
        else
        begin
            rtc_sync_q <= rtc_sync_d;
            cmp_sync_q <= cmp_sync_d;
            rtc_lvl_q <= rtc_lvl_d;
            cmp_lvl_q <= cmp_lvl_d;
            div12_q <= div12_d;
            rtc8_q <= rtc8_d;
        end
    end

    // Bus handshake: one wait cycle, read data captured in that cycle.
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
    assign wr_en = avs_write & ack_q & avs_byteenable[0];
    assign avs_readdata = rdata_q;

    always_comb
    begin
        ack_d = (avs_read | avs_write) & ~ack_q;
        rdata_d = rdata_q;
        if (avs_read && !ack_q)
        begin
            rdata_d = 32'h0000_0000;
            unique case (avs_address)
                OFS_CONTROL: rdata_d[7:0] = ctrl_q;
                OFS_COUNT_LOW: rdata_d[7:0] = cnt_q[7:0];
                OFS_COUNT_HIGH: rdata_d[7:0] = cnt_q[15:8];
                OFS_RELOAD_LOW: rdata_d[7:0] = rld_q[7:0];
                OFS_RELOAD_HIGH: rdata_d[7:0] = rld_q[15:8];
                OFS_CLOCK_CONTROL: rdata_d[2:0] = clk_q;
                default: rdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            ack_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end
        else
        begin
            ack_q <= ack_d;
            rdata_q <= rdata_d;
        end
    end

    // Counter, reload, flags and capture; bus writes to count win.
    always_comb
    begin
        ctrl_d = ctrl_q;
        clk_d = clk_q;
        cnt_d = cnt_q;
        rld_d = rld_q;
        lo_wrap = 1'b0;
        hi_wrap = 1'b0;
        low_tick = pick_tick(clk_q.low_byte_clock_select,
                             ctrl_q.alt_clock_select, div12_tick,
                             rtc8_tick, cmp_rise);
        high_tick = pick_tick(clk_q.high_byte_clock_select,
                              ctrl_q.alt_clock_select, div12_tick,
                              rtc8_tick, cmp_rise);
        if (!ctrl_q.split_mode_select)
        begin
            if (ctrl_q.run_control && low_tick)
            begin
                lo_wrap = (cnt_q[7:0] == 8'hFF);
                hi_wrap = (cnt_q == 16'hFFFF);
                cnt_d = hi_wrap ? rld_q : 16'(cnt_q + 16'h0001);
            end
        end
        else
        begin
            if (low_tick)
            begin
                lo_wrap = (cnt_q[7:0] == 8'hFF);
                cnt_d[7:0] = lo_wrap ? rld_q[7:0]
                                     : 8'(cnt_q[7:0] + 8'h01);
            end
            if (ctrl_q.run_control && high_tick)
            begin
                hi_wrap = (cnt_q[15:8] == 8'hFF);
                cnt_d[15:8] = hi_wrap ? rld_q[15:8]
                                      : 8'(cnt_q[15:8] + 8'h01);
            end
        end
        // Capture source chosen by the upper alternate clock bit.
        cap_evt = ctrl_q.capture_enable &&
                  (ctrl_q.alt_clock_select[1] ? cmp_rise
                                              : rtc8_tick);
        if (wr_en)
        begin
            unique case (avs_address)
                OFS_CONTROL: ctrl_d = avs_writedata[7:0];
                OFS_COUNT_LOW: cnt_d[7:0] = avs_writedata[7:0];
                OFS_COUNT_HIGH: cnt_d[15:8] = avs_writedata[7:0];
                OFS_RELOAD_LOW: rld_d[7:0] = avs_writedata[7:0];
                OFS_RELOAD_HIGH: rld_d[15:8] = avs_writedata[7:0];
                OFS_CLOCK_CONTROL: clk_d = avs_writedata[2:0];
                default: clk_d = clk_q;
            endcase
        end
        // Hardware sets win over a clearing write in the same cycle.
        if (hi_wrap || cap_evt)
            ctrl_d.high_overflow_flag = 1'b1;
        if (lo_wrap)
            ctrl_d.low_overflow_flag = 1'b1;
        if (cap_evt)
            rld_d = cnt_q;
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            ctrl_q <= CONTROL_RESET;
            clk_q <= CLOCK_CONTROL_RESET;
            cnt_q <= COUNT_RESET;
            rld_q <= RELOAD_RESET;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            clk_q <= clk_d;
            cnt_q <= cnt_d;
            rld_q <= rld_d;
        end
    end

    // Interrupt request follows the sticky flags and enables.
    assign timer_irq = clk_q.timer_irq_enable &
        (ctrl_q.high_overflow_flag |
         (ctrl_q.low_overflow_irq_enable &
          ctrl_q.low_overflow_flag));

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (srst);

    sequence read_waits;
        avs_read && avs_waitrequest ##1 avs_read;
    endsequence

    sequence div12_gap;
        !div12_tick [*8] ##1 !div12_tick [*3] ##1 div12_tick;
    endsequence

    bus_one_wait_a: assert property (read_waits |-> !avs_waitrequest)
        else $error("Read not answered after one wait cycle.");

    div12_period_a: assert property (div12_tick |=> div12_gap)
        else $error("Divide by 12 tick spacing wrong.");

    wrap16_reload_a: assert property (
        !ctrl_q.split_mode_select && ctrl_q.run_control && low_tick &&
        cnt_q == 16'hFFFF && !wr_en |=>
        cnt_q == $past(rld_q) && ctrl_q.high_overflow_flag)
        else $error("16-bit wrap did not reload and flag.");

    low_flag_16_a: assert property (
        !ctrl_q.split_mode_select && ctrl_q.run_control && low_tick &&
        cnt_q[7:0] == 8'hFF |=> ctrl_q.low_overflow_flag)
        else $error("Low byte wrap did not set low flag.");

    split_low_runs_a: assert property (
        ctrl_q.split_mode_select && !ctrl_q.run_control && low_tick &&
        cnt_q[7:0] != 8'hFF && !wr_en |=>
        cnt_q[7:0] == 8'($past(cnt_q[7:0]) + 8'h01))
        else $error("Split low byte did not count.");

    split_high_hold_a: assert property (
        ctrl_q.split_mode_select && !ctrl_q.run_control && !wr_en
        |=> $stable(cnt_q[15:8]))
        else $error("Stopped high byte moved.");

    irq_high_a: assert property (
        clk_q.timer_irq_enable && ctrl_q.high_overflow_flag |-> timer_irq)
        else $error("High overflow did not request interrupt.");

    irq_low_gate_a: assert property (
        !ctrl_q.low_overflow_irq_enable && !ctrl_q.high_overflow_flag
        |-> !timer_irq)
        else $error("Interrupt raised without enabled source.");

    capture_load_a: assert property (
        cap_evt && !wr_en |=>
        rld_q == $past(cnt_q) && ctrl_q.high_overflow_flag)
        else $error("Capture did not load reload or set flag.");

    flag_sticky_a: assert property (
        ctrl_q.high_overflow_flag && !wr_en |=> ctrl_q.high_overflow_flag)
        else $error("High flag cleared by hardware.");

    reset_clear_a: assert property (disable iff (1'b0)
        srst |=> cnt_q == COUNT_RESET && ctrl_q == CONTROL_RESET &&
        rld_q == RELOAD_RESET)
        else $error("Reset did not clear timer state.");

endmodule : reload_timer_with_capture

/* File: reload_timer_with_capture_test.sv */
// Purpose: Self-checking bench for the reload timer with capture.
// Assumes: The block answers each access after its own wait cycles.
// Notes: Count and capture sources are driven as slow level pulses.
module reload_timer_with_capture_test
    import timer_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;

    // Design inputs, outputs and bench bookkeeping.
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata, q;
    logic avs_waitrequest, timer_irq;
    logic rtc_osc = 1'b0;
    logic cmp0_out = 1'b0;
    logic [15:0] c1, dif;
    logic [7:0] lo;
    int err_count = 0, n_checks = 0, cyc = 0, t1;

    // Clock and a free cycle counter for spacing capture edges.
    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) cyc <= cyc + 1;

    reload_timer_with_capture reload_timer_with_capture_i (
        .ref_clk(ref_clk), .srst(srst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .rtc_osc(rtc_osc), .cmp0_out(cmp0_out), .timer_irq(timer_irq));

    // Prints the counts and the verdict, then stops the run.
    task automatic conclude();
        $display("Checks %0d, mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : conclude

    // Compares a seen value with the expected one.
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("[FAIL] %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // One bus cycle; the request holds until waitrequest is seen low.
    task automatic acc(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= ~w;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 40);
        q = avs_readdata;
        if (n >= 40)
        begin
            err_count++;
            conclude();
        end
        @(posedge ref_clk);
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : acc

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        acc(1'b1, a, {24'h0, d});
    endtask : wr

    // Reads a register and compares its low byte.
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        acc(1'b0, a, 32'h0);
        check(q, {24'h0, e});
    endtask : rc

    // Samples the interrupt line once the last edge has settled.
    task automatic irq(input logic e);
        @(negedge ref_clk);
        check({31'h0, timer_irq}, {31'h0, e});
    endtask : irq

    // Polls the control register until the given bit is set.
    task automatic wait_flag(input int b);
        int n;
        n = 0;
        q = 32'h0;
        while (q[b] !== 1'b1 && n < 100)
        begin
            acc(1'b0, OFS_CONTROL, 32'h0);
            n++;
        end
        if (n >= 100)
        begin
            err_count++;
            conclude();
        end
    endtask : wait_flag

    // Gives k rising edges on the oscillator or the comparator input.
    task automatic pulse(input logic rtc, input int k, input int half);
        repeat (k)
        begin
            @(posedge ref_clk);
            if (rtc) rtc_osc <= 1'b1; else cmp0_out <= 1'b1;
            repeat (half) @(posedge ref_clk);
            if (rtc) rtc_osc <= 1'b0; else cmp0_out <= 1'b0;
            repeat (half - 1) @(posedge ref_clk);
        end
    endtask : pulse

    // Hang guard.
    initial
    begin
        repeat (60000) @(posedge ref_clk);
        err_count++;
        conclude();
    end

    // Main sequence: reset, wrap, split, sources, capture.
    initial
    begin
        repeat (20) @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        irq(1'b0);
        for (int a = 0; a <= 20; a += 4) rc(8'(a), 8'h00);
        rc(8'h18, 8'h00);
        avs_byteenable <= 4'h0;
        wr(OFS_COUNT_HIGH, 8'h77);
        avs_byteenable <= 4'hF;
        rc(OFS_COUNT_HIGH, 8'h00);
        // Full 16-bit wrap with reload.
        wr(OFS_CLOCK_CONTROL, 8'h01);
        wr(OFS_COUNT_LOW, 8'hFE);
        wr(OFS_COUNT_HIGH, 8'hFF);
        wr(OFS_RELOAD_LOW, 8'h34);
        wr(OFS_RELOAD_HIGH, 8'h12);
        wr(OFS_CONTROL, 8'h04);
        rc(OFS_CONTROL, 8'hC4);
        irq(1'b0);
        rc(OFS_COUNT_HIGH, 8'h12);
        wr(OFS_CLOCK_CONTROL, 8'h05);
        irq(1'b1);
        repeat (30) @(posedge ref_clk);
        rc(OFS_CONTROL, 8'hC4);
        wr(OFS_CONTROL, 8'h00);
        irq(1'b0);
        // Low byte wrap only, with and without its interrupt enable.
        wr(OFS_COUNT_LOW, 8'hFE);
        wr(OFS_COUNT_HIGH, 8'h00);
        wr(OFS_CONTROL, 8'h24);
        repeat (4) @(posedge ref_clk);
        irq(1'b1);
        rc(OFS_CONTROL, 8'h64);
        wr(OFS_CONTROL, 8'h04);
        wr(OFS_COUNT_LOW, 8'hFE);
        repeat (4) @(posedge ref_clk);
        irq(1'b0);
        rc(OFS_CONTROL, 8'h44);
        wr(OFS_CONTROL, 8'h00);
        // Split mode: low byte free running, high byte gated and slow.
        wr(OFS_RELOAD_LOW, 8'hA0);
        wr(OFS_COUNT_LOW, 8'hFE);
        wr(OFS_COUNT_HIGH, 8'h10);
        wr(OFS_RELOAD_HIGH, 8'h55);
        wr(OFS_CONTROL, 8'h08);
        repeat (4) @(posedge ref_clk);
        rc(OFS_CONTROL, 8'h48);
        irq(1'b0);
        rc(OFS_COUNT_HIGH, 8'h10);
        acc(1'b0, OFS_COUNT_LOW, 32'h0);
        check(32'(q[7:5]), 32'h5);
        wr(OFS_COUNT_HIGH, 8'hFF);
        wr(OFS_CONTROL, 8'h0C);
        wait_flag(7);
        irq(1'b1);
        acc(1'b0, OFS_COUNT_HIGH, 32'h0);
        check(32'(q[7:4]), 32'h5);
        wr(OFS_CONTROL, 8'h00);
        // Alternate count sources in 16-bit mode, each from a zero count.
        wr(OFS_CLOCK_CONTROL, 8'h00);
        wr(OFS_COUNT_LOW, 8'h00);
        wr(OFS_COUNT_HIGH, 8'h00);
        wr(OFS_CONTROL, 8'h04);
        repeat (120) @(posedge ref_clk);
        wr(OFS_CONTROL, 8'h00);
        acc(1'b0, OFS_COUNT_LOW, 32'h0);
        check(32'(q[7:0] >= 8'h09 && q[7:0] <= 8'h0B), 32'h1);
        wr(OFS_COUNT_LOW, 8'h00);
        wr(OFS_CONTROL, 8'h07);
        pulse(1'b0, 3, 8);
        repeat (10) @(posedge ref_clk);
        wr(OFS_CONTROL, 8'h00);
        rc(OFS_COUNT_LOW, 8'h03);
        wr(OFS_COUNT_LOW, 8'h00);
        wr(OFS_CONTROL, 8'h05);
        pulse(1'b1, 16, 4);
        repeat (10) @(posedge ref_clk);
        wr(OFS_CONTROL, 8'h00);
        rc(OFS_COUNT_LOW, 8'h02);
        wr(OFS_COUNT_LOW, 8'h00);
        wr(OFS_CONTROL, 8'h06);
        pulse(1'b0, 2, 8);
        wr(OFS_CONTROL, 8'h00);
        rc(OFS_COUNT_LOW, 8'h00);
        // Capture on two comparator rises exactly 200 cycles apart.
        wr(OFS_CLOCK_CONTROL, 8'h05);
        wr(OFS_CONTROL, 8'h16);
        pulse(1'b0, 1, 8);
        t1 = cyc;
        repeat (20) @(posedge ref_clk);
        rc(OFS_CONTROL, 8'h96);
        irq(1'b1);
        acc(1'b0, OFS_RELOAD_LOW, 32'h0);
        c1[7:0] = q[7:0];
        acc(1'b0, OFS_RELOAD_HIGH, 32'h0);
        c1[15:8] = q[7:0];
        wr(OFS_CONTROL, 8'h16);
        irq(1'b0);
        while (cyc < t1 + 184) @(posedge ref_clk);
        pulse(1'b0, 1, 8);
        repeat (20) @(posedge ref_clk);
        irq(1'b1);
        acc(1'b0, OFS_RELOAD_LOW, 32'h0);
        lo = q[7:0];
        acc(1'b0, OFS_RELOAD_HIGH, 32'h0);
        dif = {q[7:0], lo} - c1;
        check(32'(dif), 32'h0000_00C8);
        conclude();
    end

endmodule : reload_timer_with_capture_test

/* File: timer_pkg.sv */
// Purpose: Shared constants and carriers for the reload timer with capture.
// Assumes: Registers are 32-bit Avalon-MM words, data in the low byte.
// Notes: Offsets are byte addresses; word index is address bits [7:2].
package timer_pkg;

    // Register byte offsets.
    localparam logic [7:0] OFS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_COUNT_LOW = 8'h04;
    localparam logic [7:0] OFS_COUNT_HIGH = 8'h08;
    localparam logic [7:0] OFS_RELOAD_LOW = 8'h0C;
    localparam logic [7:0] OFS_RELOAD_HIGH = 8'h10;
    localparam logic [7:0] OFS_CLOCK_CONTROL = 8'h14;

    // Field positions in the clock control register.
    localparam int POS_LOW_CLK_SEL = 0;
    localparam int POS_HIGH_CLK_SEL = 1;
    localparam int POS_IRQ_ENABLE = 2;

    // Alternate clock field codes.
    localparam logic [1:0] ALT_SYS_DIV12 = 2'h0;
    localparam logic [1:0] ALT_RTC_DIV8 = 2'h1;
    localparam logic [1:0] ALT_COMPARATOR = 2'h3;

    // Prescaler counts.
    localparam logic [3:0] DIV12_LAST = 4'hB;
    localparam logic [2:0] RTC_DIV_LAST = 3'h7;

    // Values after reset.
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] RELOAD_RESET = 16'h0000;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [2:0] CLOCK_CONTROL_RESET = 3'h0;

    // Control register, bit 7 down to bit 0.
    typedef struct packed {
        logic high_overflow_flag;
        logic low_overflow_flag;
        logic low_overflow_irq_enable;
        logic capture_enable;
        logic split_mode_select;
        logic run_control;
        logic [1:0] alt_clock_select;
    } control_t;

    // Clock control register, bit 2 down to bit 0.
    typedef struct packed {
        logic timer_irq_enable;
        logic high_byte_clock_select;
        logic low_byte_clock_select;
    } clock_control_t;

endpackage : timer_pkg
